// ===== common/vrm_pkg.sv
// Package: register map, reset values and carriers of the voice ROM mixer
package vrm_pkg;

  // ---------------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ---------------------------------------------------------------------
  localparam logic [7:0] IDX_PTR_LOW = 8'h20;
  localparam logic [7:0] IDX_PTR_HIGH = 8'h21;
  localparam logic [7:0] IDX_BANK = 8'h22;
  localparam logic [7:0] IDX_CH2_ROM_BUF = 8'h23;
  localparam logic [7:0] IDX_CH2_OUT_BUF = 8'h24;
  localparam logic [7:0] IDX_HI_NIB_UPPER = 8'h25;
  localparam logic [7:0] IDX_LO_NIB_UPPER = 8'h26;
  localparam logic [7:0] IDX_HI_NIB_LOWER = 8'h27;
  localparam logic [7:0] IDX_LO_NIB_LOWER = 8'h28;
  localparam logic [7:0] IDX_AUDIO_CTRL = 8'h29;
  localparam logic [7:0] IDX_VOLUME = 8'h2A;
  localparam logic [7:0] IDX_MIXER_CTRL = 8'h2B;
  localparam logic [7:0] IDX_CH2_POLARITY = 8'h2C;
  localparam logic [7:0] IDX_FETCH_CTRL = 8'h2D;

  // ---------------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------------
  localparam logic [7:0] RST_PTR_LOW = 8'h00;
  localparam logic [7:0] RST_PTR_HIGH = 8'hC0;
  localparam logic [2:0] RST_BANK = 3'h0;
  localparam logic [7:0] RST_CH2_ROM_BUF = 8'hFF;
  localparam logic [7:0] RST_ROM_BYTE = 8'hFF;
  localparam logic [3:0] RST_VOLUME = 4'hF;
  localparam logic [7:0] PTR_ALL_ONES = 8'hFF;
  localparam logic [7:0] PTR_HIGH_RELOAD = 8'hC0;

  // ---------------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------------
  localparam int MIX_DBL0_BIT = 4;
  localparam int MIX_MODE_LSB = 5;
  localparam int MIX_PWM_BIT = 7;
  localparam int AUD_EN_BIT = 0;
  localparam int AUD_INTERP_BIT = 1;
  localparam int POL_SIGN_BIT = 4;
  localparam int FCTL_AUTO_BIT = 0;
  localparam int FCTL_FULL_BIT = 6;
  localparam int FCTL_BUSY_BIT = 7;
  localparam int VOL_TOP_BIT = 3;
  localparam logic [1:0] MODE_DOUBLE_PS = 2'b10;
  localparam logic [1:0] MODE_CH2_X4 = 2'b11;

  // Sample handed to the PWM/DAC stage
  typedef struct packed {
    logic [9:0] total;
    logic [3:0] volume;
    logic pwm_sel;
  } vrm_sample_t;

  // Voice ROM fetch request
  typedef struct packed {
    logic [2:0] bank;
    logic [13:0] offset;
  } vrm_rom_addr_t;

endpackage : vrm_pkg

// ===== logic/vrm_mixer.sv
// Voice ROM fetch, nibble views, channel mixer and sample FIFO over APB
//
// Behaviour
// - Pointer low byte is read/write and clears to zero at reset.
// - Pointer high byte is read/write and resets to C0.
// - A 3-bit read/write bank selects one of eight 16 KB banks, reset 0.
// - Channel-2 output buffer is read/write, reset all zeros or all ones.
// - Upper nibble of the ROM byte reads in bits 7:4 and in bits 3:0.
// - Lower nibble of the ROM byte reads in bits 7:4 and in bits 3:0.
// - A 4-bit read/write volume resets to all ones (7 with 8 levels), 8 or 16 levels.
// - Mixer control bits 3:0 read the top four bits of the mixer result.
// - Mixer bit 4 picks the partial sum, bits 6:5 pick the total.
// - With auto-increment, a low byte wrap advances the high byte.
// - With auto-increment, a double wrap bumps the bank, high reloads C0.
`timescale 1ns/100ps
`default_nettype none

// -----------------------------------------------------------------------
// Shift-register FIFO: the head always sits in slot 0, so data is a flop
// -----------------------------------------------------------------------
module vrm_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int CW = $clog2(DEPTH + 1);
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [CW-1:0] count_r;
  logic push;
  logic pop;

  // Handshakes
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign in_ready = (count_r != CW'(DEPTH));
  assign out_data = mem_r[0];

  // Occupancy and head valid
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      count_r <= '0;
      out_valid <= 1'b0;
    end else begin
      count_r <= count_r + CW'(push) - CW'(pop);
      out_valid <= (count_r + CW'(push) - CW'(pop)) != '0;
    end
  end

  // Storage shifts toward the head on every pop
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_r[i] <= '0;
      end
    end else begin
      for (int i = 0; i < DEPTH; i++) begin
        if (push && (CW'(i) == count_r - CW'(pop))) begin
          mem_r[i] <= in_data;
        end else if (pop && (i < DEPTH - 1)) begin
          mem_r[i] <= mem_r[i+1];
        end
      end
    end
  end
endmodule : vrm_fifo

// -----------------------------------------------------------------------
// Top: APB register file, ROM fetch and mixer
// -----------------------------------------------------------------------
module vrm_mixer #(
  parameter bit OBF_RESET_ONES = 1'b0,
  parameter logic [3:0] MIX_MSB_RESET = 4'h8,
  parameter bit PWM_RESET = 1'b1,
  parameter bit SIGN_RESET = 1'b0,
  parameter bit VOL_8LEVEL = 1'b0,
  parameter int FIFO_DEPTH = 4
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Voice ROM port
  output logic rom_req,
  output vrm_pkg::vrm_rom_addr_t rom_addr,
  input wire logic rom_valid,
  input wire logic [7:0] rom_data,
  // Other voice channels
  input wire logic [7:0] voice_channel_zero,
  input wire logic [7:0] voice_channel_one,
  // Sample stream to PWM/DAC
  output logic sample_valid,
  input wire logic sample_ready,
  output vrm_pkg::vrm_sample_t sample_data,
  // Audio control levels
  output logic audio_enable,
  output logic interp_enable
);
  typedef enum logic [1:0] {
    FETCH_IDLE = 2'b01,
    FETCH_WAIT = 2'b10
  } vrm_fetch_t;

  // Registers
  logic [7:0] ptr_low_r;
  logic [7:0] ptr_high_r;
  logic [2:0] bank_r;
  logic [7:0] ch2_rom_r;
  logic [7:0] ch2_out_r;
  logic [7:0] rom_byte_r;
  logic [1:0] aud_r;
  logic [3:0] vol_r;
  logic [3:0] mix_cfg_r;
  logic [3:0] mix_msb_r;
  logic sign_r;
  logic auto_inc_r;
  logic fetch_pend_r;
  vrm_fetch_t fetch_r;

  // Bus decode
  logic [7:0] idx;
  logic mapped;
  logic setup_ok;
  logic commit;
  logic wr;
  logic rd;
  logic stall;
  logic [7:0] rdata;

  // Mixer and FIFO
  logic [9:0] total_nxt;
  logic push;
  logic fifo_ready;
  vrm_pkg::vrm_sample_t sample_nxt;

  assign idx = paddr[9:2];
  assign mapped = (paddr[1:0] == 2'b00) && (paddr[11:10] == 2'b00) &&
                  (idx >= vrm_pkg::IDX_PTR_LOW) &&
                  (idx <= vrm_pkg::IDX_FETCH_CTRL);
  assign commit = psel && penable && pready;
  assign wr = commit && pwrite && mapped;
  assign rd = commit && !pwrite && mapped;
  // A sample write waits for FIFO room so no sample is ever dropped
  assign stall = pwrite && (idx == vrm_pkg::IDX_CH2_ROM_BUF) &&
                 aud_r[vrm_pkg::AUD_EN_BIT] && !fifo_ready;
  assign setup_ok = psel && penable && !pready && !(mapped && stall);

  // ---------------------------------------------------------------------
  // Mixer datapath
  // ---------------------------------------------------------------------
  function automatic logic [9:0] mix_total(input logic [7:0] c0,
      input logic [7:0] c1, input logic [7:0] c2, input logic dbl0,
      input logic [1:0] mode);
    logic [8:0] ps;
    logic [9:0] tot;
    ps = dbl0 ? {c0, 1'b0} : ({1'b0, c0} + {1'b0, c1});
    unique case (mode)
      vrm_pkg::MODE_DOUBLE_PS: tot = {ps, 1'b0};
      vrm_pkg::MODE_CH2_X4: tot = {c2, 2'b00};
      default: tot = {1'b0, ps} + {1'b0, c2, 1'b0};
    endcase
    return tot;
  endfunction : mix_total

  // New channel-2 value enters the mixer on the sample write itself
  always_comb begin
    logic [7:0] c2;
    c2 = pwdata[7:0];
    if (sign_r) begin
      c2 = ~c2;
    end
    total_nxt = mix_total(voice_channel_zero, voice_channel_one, c2,
                          mix_cfg_r[0], mix_cfg_r[2:1]);
    sample_nxt.total = total_nxt;
    sample_nxt.volume = vol_r;
    sample_nxt.pwm_sel = mix_cfg_r[3];
  end

  assign push = wr && (idx == vrm_pkg::IDX_CH2_ROM_BUF) &&
                aud_r[vrm_pkg::AUD_EN_BIT];

  vrm_fifo #(
    .WIDTH($bits(vrm_pkg::vrm_sample_t)),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clock(clock),
    .rst_n(rst_n),
    .in_valid(push),
    .in_ready(fifo_ready),
    .in_data(sample_nxt),
    .out_valid(sample_valid),
    .out_ready(sample_ready),
    .out_data(sample_data)
  );

  // ---------------------------------------------------------------------
  // Read mux
  // ---------------------------------------------------------------------
  always_comb begin
    rdata = 8'h00;
    unique case (idx)
      vrm_pkg::IDX_PTR_LOW: rdata = ptr_low_r;
      vrm_pkg::IDX_PTR_HIGH: rdata = ptr_high_r;
      vrm_pkg::IDX_BANK: rdata = {5'h00, bank_r};
      vrm_pkg::IDX_CH2_OUT_BUF: rdata = ch2_out_r;
      vrm_pkg::IDX_HI_NIB_UPPER: rdata = {rom_byte_r[7:4], 4'h0};
      vrm_pkg::IDX_HI_NIB_LOWER: rdata = {4'h0, rom_byte_r[7:4]};
      vrm_pkg::IDX_LO_NIB_UPPER: rdata = {rom_byte_r[3:0], 4'h0};
      vrm_pkg::IDX_LO_NIB_LOWER: rdata = {4'h0, rom_byte_r[3:0]};
      vrm_pkg::IDX_AUDIO_CTRL: rdata = {6'h00, aud_r};
      vrm_pkg::IDX_VOLUME: rdata = {4'h0, vol_r};
      vrm_pkg::IDX_MIXER_CTRL: rdata = {mix_cfg_r, mix_msb_r};
      vrm_pkg::IDX_CH2_POLARITY: rdata = {3'h0, sign_r, 4'h0};
      // Busy also covers a queued fetch, so a poll never sees a false idle
      vrm_pkg::IDX_FETCH_CTRL: rdata = {(fetch_r == FETCH_WAIT) ||
                                        fetch_pend_r,
                                        !fifo_ready, 5'h00, auto_inc_r};
      default: rdata = 8'h00;
    endcase
  end

  // APB answer: ready one cycle into the access phase, held off on stall
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready <= setup_ok;
      if (setup_ok) begin
        prdata <= (mapped && !pwrite) ? {24'h00_0000, rdata} : 32'h0000_0000;
        pslverr <= !mapped;
      end
    end
  end

  // ---------------------------------------------------------------------
  // Voice pointer and bank with auto-increment
  // ---------------------------------------------------------------------
  // Reading the last nibble view steps the pointer to the next byte
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ptr_low_r <= vrm_pkg::RST_PTR_LOW;
      ptr_high_r <= vrm_pkg::RST_PTR_HIGH;
      bank_r <= vrm_pkg::RST_BANK;
    end else if (wr) begin
      if (idx == vrm_pkg::IDX_PTR_LOW) ptr_low_r <= pwdata[7:0];
      if (idx == vrm_pkg::IDX_PTR_HIGH) ptr_high_r <= pwdata[7:0];
      if (idx == vrm_pkg::IDX_BANK) bank_r <= pwdata[2:0];
    end else if (rd && (idx == vrm_pkg::IDX_LO_NIB_LOWER)) begin
      ptr_low_r <= ptr_low_r + 8'h01;
      if (auto_inc_r && (ptr_low_r == vrm_pkg::PTR_ALL_ONES)) begin
        if (ptr_high_r == vrm_pkg::PTR_ALL_ONES) begin
          bank_r <= bank_r + 3'h1;
          ptr_high_r <= vrm_pkg::PTR_HIGH_RELOAD;
        end else begin
          ptr_high_r <= ptr_high_r + 8'h01;
        end
      end
    end
  end

  // ---------------------------------------------------------------------
  // Control and data registers
  // ---------------------------------------------------------------------
  // Writes to the nibble views fall through every branch here
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ch2_rom_r <= vrm_pkg::RST_CH2_ROM_BUF;
      ch2_out_r <= {8{OBF_RESET_ONES}};
      aud_r <= 2'b00;
      vol_r <= VOL_8LEVEL ? 4'h7 : vrm_pkg::RST_VOLUME;
      mix_cfg_r <= {PWM_RESET, 3'b000};
      sign_r <= SIGN_RESET;
      auto_inc_r <= 1'b0;
    end else if (wr) begin
      unique case (idx)
        vrm_pkg::IDX_CH2_ROM_BUF: begin
          ch2_rom_r <= pwdata[7:0];
          ch2_out_r <= pwdata[7:0];
        end
        vrm_pkg::IDX_CH2_OUT_BUF: ch2_out_r <= pwdata[7:0];
        vrm_pkg::IDX_AUDIO_CTRL: aud_r <= pwdata[1:0];
        vrm_pkg::IDX_VOLUME: begin
          vol_r <= pwdata[3:0];
          if (VOL_8LEVEL) vol_r[vrm_pkg::VOL_TOP_BIT] <= 1'b0;
        end
        vrm_pkg::IDX_MIXER_CTRL: mix_cfg_r <= pwdata[7:4];
        vrm_pkg::IDX_CH2_POLARITY: sign_r <= pwdata[vrm_pkg::POL_SIGN_BIT];
        vrm_pkg::IDX_FETCH_CTRL:
          auto_inc_r <= pwdata[vrm_pkg::FCTL_AUTO_BIT];
        default: ;
      endcase
    end
  end

  // Mixer top bits latch the total of every pushed sample
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      mix_msb_r <= MIX_MSB_RESET;
    end else if (push) begin
      mix_msb_r <= total_nxt[9:6];
    end
  end

  // Audio control levels to the output stage
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      audio_enable <= 1'b0;
      interp_enable <= 1'b0;
    end else begin
      audio_enable <= aud_r[vrm_pkg::AUD_EN_BIT];
      interp_enable <= aud_r[vrm_pkg::AUD_INTERP_BIT];
    end
  end

  // ---------------------------------------------------------------------
  // ROM fetch: refetch whenever the pointer moves; a move during a
  // fetch re-arms the request so the stale byte is soon replaced
  // ---------------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      fetch_r <= FETCH_IDLE;
      fetch_pend_r <= 1'b1;
      rom_req <= 1'b0;
      rom_addr <= '0;
      rom_byte_r <= vrm_pkg::RST_ROM_BYTE;
    end else begin
      rom_req <= 1'b0;
      if ((wr && (idx <= vrm_pkg::IDX_BANK)) ||
          (rd && (idx == vrm_pkg::IDX_LO_NIB_LOWER))) begin
        fetch_pend_r <= 1'b1;
      end
      unique case (fetch_r)
        FETCH_IDLE: begin
          if (fetch_pend_r && !commit) begin
            fetch_pend_r <= 1'b0;
            rom_req <= 1'b1;
            rom_addr.bank <= bank_r;
            rom_addr.offset <= {ptr_high_r[5:0], ptr_low_r};
            fetch_r <= FETCH_WAIT;
          end
        end
        FETCH_WAIT: begin
          if (rom_valid) begin
            rom_byte_r <= rom_data;
            fetch_r <= FETCH_IDLE;
          end
        end
        default: fetch_r <= FETCH_IDLE;
      endcase
    end
  end

  // ---------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);

  sequence s_wrap_read;
    rd && (idx == vrm_pkg::IDX_LO_NIB_LOWER) && auto_inc_r &&
    (ptr_low_r == vrm_pkg::PTR_ALL_ONES);
  endsequence

  property p_ptr_low_wr;
    wr && (idx == vrm_pkg::IDX_PTR_LOW) |=> ptr_low_r == $past(pwdata[7:0]);
  endproperty
  a_ptr_low_wr: assert property (p_ptr_low_wr)
    else $error("pointer low write lost");

  property p_ptr_high_wr;
    wr && (idx == vrm_pkg::IDX_PTR_HIGH) |=>
      ptr_high_r == $past(pwdata[7:0]);
  endproperty
  a_ptr_high_wr: assert property (p_ptr_high_wr)
    else $error("pointer high write lost");

  property p_bank_rd;
    rd && (idx == vrm_pkg::IDX_BANK) |-> prdata[7:3] == 5'h00 &&
      prdata[2:0] == bank_r;
  endproperty
  a_bank_rd: assert property (p_bank_rd)
    else $error("bank readback wrong");

  property p_obf_rd;
    rd && (idx == vrm_pkg::IDX_CH2_OUT_BUF) |->
      prdata[7:0] == $past(ch2_out_r);
  endproperty
  a_obf_rd: assert property (p_obf_rd)
    else $error("output buffer readback wrong");

  property p_hi_nib;
    rd && (idx == vrm_pkg::IDX_HI_NIB_UPPER) |->
      prdata[3:0] == 4'h0 && prdata[7:4] == $past(rom_byte_r[7:4]);
  endproperty
  a_hi_nib: assert property (p_hi_nib)
    else $error("upper nibble view wrong");

  property p_lo_nib;
    rd && (idx == vrm_pkg::IDX_LO_NIB_LOWER) |->
      prdata[7:4] == 4'h0 && prdata[3:0] == $past(rom_byte_r[3:0]);
  endproperty
  a_lo_nib: assert property (p_lo_nib)
    else $error("lower nibble view wrong");

  property p_vol_8;
    wr && (idx == vrm_pkg::IDX_VOLUME) |=>
      vol_r[2:0] == $past(pwdata[2:0]) &&
      vol_r[vrm_pkg::VOL_TOP_BIT] == (!VOL_8LEVEL && $past(pwdata[3]));
  endproperty
  a_vol_8: assert property (p_vol_8)
    else $error("volume write wrong");

  property p_mix_msb;
    push |=> mix_msb_r == $past(total_nxt[9:6]) && sample_valid;
  endproperty
  a_mix_msb: assert property (p_mix_msb)
    else $error("mixer top bits not latched");

  property p_mix_x4;
    push && (mix_cfg_r[2:1] == vrm_pkg::MODE_CH2_X4) |->
      total_nxt == {(sign_r ? ~pwdata[7:0] : pwdata[7:0]), 2'b00};
  endproperty
  a_mix_x4: assert property (p_mix_x4)
    else $error("channel two times four wrong");

  property p_carry;
    s_wrap_read and (ptr_high_r != vrm_pkg::PTR_ALL_ONES) |=>
      ptr_high_r == $past(ptr_high_r) + 8'h01 && ptr_low_r == 8'h00;
  endproperty
  a_carry: assert property (p_carry)
    else $error("high byte did not advance");

  property p_bank_bump;
    s_wrap_read and (ptr_high_r == vrm_pkg::PTR_ALL_ONES) |=>
      bank_r == $past(bank_r) + 3'h1 &&
      ptr_high_r == vrm_pkg::PTR_HIGH_RELOAD;
  endproperty
  a_bank_bump: assert property (p_bank_bump)
    else $error("bank bump or reload wrong");

  property p_ro_wr;
    wr && (idx >= vrm_pkg::IDX_HI_NIB_UPPER) &&
      (idx <= vrm_pkg::IDX_LO_NIB_LOWER) && !rom_valid |=>
      $stable(rom_byte_r);
  endproperty
  a_ro_wr: assert property (p_ro_wr)
    else $error("nibble view changed by write");
endmodule : vrm_mixer

`default_nettype wire

// ===== tb/vrm_far_model.sv
// Far-side model: voice ROM answering fetches and a stallable sample sink
`timescale 1ns/100ps
`default_nettype none
module vrm_far_model #(
  parameter int SLOW_WAIT = 5
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Voice ROM port
  input wire logic rom_req,
  input wire vrm_pkg::vrm_rom_addr_t rom_addr,
  output logic rom_valid,
  output logic [7:0] rom_data,
  // Sample sink
  input wire logic sample_valid,
  output logic sample_ready,
  input wire vrm_pkg::vrm_sample_t sample_data,
  // Bench control and observation
  input wire logic slow,
  input wire logic stall,
  output logic [7:0] pops,
  output vrm_pkg::vrm_sample_t last
);
  logic busy_r;
  logic [7:0] wait_r;
  logic [7:0] byte_r;

  // ROM content is the offset low byte scrambled, so each low byte value gives a distinct byte
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      busy_r <= 1'b0;
      wait_r <= 8'h00;
      byte_r <= 8'h00;
      rom_valid <= 1'b0;
    end else begin
      rom_valid <= 1'b0;
      if (rom_req) begin
        busy_r <= 1'b1;
        wait_r <= slow ? 8'(SLOW_WAIT) : 8'h00;
        byte_r <= rom_addr.offset[7:0] ^ 8'hA5;
      end else if (busy_r && wait_r != 8'h00) begin
        wait_r <= wait_r - 8'h01;
      end else if (busy_r) begin
        busy_r <= 1'b0;
        rom_valid <= 1'b1;
      end
    end
  end

  // Data is inverted outside the answer cycle so a late sample shows up
  assign rom_data = rom_valid ? byte_r : ~byte_r;
  assign sample_ready = !stall;

  // Record every popped sample
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pops <= 8'h00;
      last <= '0;
    end else if (sample_valid && sample_ready) begin
      pops <= pops + 8'h01;
      last <= sample_data;
    end
  end
endmodule : vrm_far_model
`default_nettype wire

// ===== tb/vrm_mixer_tb_top.sv
// Testbench: APB register sequences against the voice ROM mixer
`timescale 1ns/100ps
`default_nettype none
module vrm_mixer_tb_top;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic rom_req;
  vrm_pkg::vrm_rom_addr_t rom_addr;
  logic rom_valid;
  logic [7:0] rom_data;
  logic [7:0] voice_channel_zero = 8'hC3;
  logic [7:0] voice_channel_one = 8'h5E;
  logic sample_valid;
  logic sample_ready;
  vrm_pkg::vrm_sample_t sample_data;
  logic audio_enable;
  logic interp_enable;
  logic slow = 1'b0;
  logic stall = 1'b0;
  logic [7:0] pops;
  vrm_pkg::vrm_sample_t last;
  int failures = 0;
  int total_checks = 0;
  logic [31:0] d;
  logic e;
  logic [9:0] t;
  logic [7:0] n;

  always #50 clock = ~clock;

  vrm_mixer i_dut (.clock(clock), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .rom_req(rom_req),
    .rom_addr(rom_addr), .rom_valid(rom_valid), .rom_data(rom_data),
    .voice_channel_zero(voice_channel_zero),
    .voice_channel_one(voice_channel_one), .sample_valid(sample_valid),
    .sample_ready(sample_ready), .sample_data(sample_data),
    .audio_enable(audio_enable), .interp_enable(interp_enable));

  vrm_far_model i_far (.clock(clock), .rst_n(rst_n), .rom_req(rom_req),
    .rom_addr(rom_addr), .rom_valid(rom_valid), .rom_data(rom_data),
    .sample_valid(sample_valid), .sample_ready(sample_ready),
    .sample_data(sample_data), .slow(slow), .stall(stall), .pops(pops),
    .last(last));

  // -------------------------------------------------------------------
  // Bus and compare tasks
  // -------------------------------------------------------------------
  task automatic results();
    if (failures == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : results

  task automatic chk(input string nm, input logic [31:0] x,
                     input logic [31:0] g);
    total_checks++;
    if (g !== x) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", nm, x, g);
    end
  endtask : chk

  // Request held until pready is sampled high; data taken at that edge
  task automatic apb(input logic w, input logic [7:0] idx,
                     input logic [7:0] wd, output logic [31:0] rd,
                     output logic er);
    int i;
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= {24'h00_0000, wd};
    @(posedge clock);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge clock);
      i++;
    end while (pready !== 1'b1 && i < 50);
    if (i >= 50) chk("pready", 32'h0000_0001, 32'h0000_0000);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] idx, input logic [7:0] wd);
    logic [31:0] r;
    logic x;
    apb(1'b1, idx, wd, r, x);
  endtask : wr

  task automatic rd(input logic [7:0] idx, input logic [7:0] x,
                    input string nm);
    logic [31:0] r;
    logic y;
    apb(1'b0, idx, 8'h00, r, y);
    chk(nm, {24'h00_0000, x}, r);
  endtask : rd

  // Poll the fetch busy flag; a fetch that never lands fails the check
  task automatic wait_idle();
    logic [31:0] r;
    logic y;
    r = 32'h0000_0080;
    for (int i = 0; i < 20 && r[7] !== 1'b0; i++) apb(1'b0, 8'h2D, 8'h00, r, y);
    chk("fetch idle", 32'h0000_0000, {31'h0, r[7]});
  endtask : wait_idle

  task automatic nib(input logic [7:0] b);
    rd(8'h25, {b[7:4], 4'h0}, "hi nibble upper");
    rd(8'h26, {b[3:0], 4'h0}, "lo nibble upper");
    rd(8'h27, {4'h0, b[7:4]}, "hi nibble lower");
    rd(8'h28, {4'h0, b[3:0]}, "lo nibble lower");
  endtask : nib

  task automatic wait_pops(input logic [7:0] x);
    repeat (40) if (pops !== x) @(posedge clock);
    chk("pops", {24'h00_0000, x}, {24'h00_0000, pops});
  endtask : wait_pops

  // Step pointer by reading the low nibble view, then check the carry
  task automatic step(input logic [7:0] hi, input logic [7:0] xhi,
                      input logic [2:0] xbk);
    wr(8'h21, hi);
    wr(8'h20, 8'hFF);
    wait_idle();
    apb(1'b0, 8'h28, 8'h00, d, e);
    wait_idle();
    rd(8'h20, 8'h00, "ptr low wrap");
    rd(8'h21, xhi, "ptr high carry");
    rd(8'h22, {5'h00, xbk}, "bank carry");
  endtask : step

  function automatic logic [9:0] mix(input logic [7:0] a, input logic [7:0] b,
      input logic [7:0] c, input logic dbl, input logic [1:0] m);
    logic [9:0] ps;
    ps = dbl ? {1'b0, a, 1'b0} : 10'(a) + 10'(b);
    if (m == 2'b11) return {c, 2'b00};
    if (m == 2'b10) return {ps[8:0], 1'b0};
    return ps + {1'b0, c, 1'b0};
  endfunction : mix

  // -------------------------------------------------------------------
  // Main sequence
  // -------------------------------------------------------------------
  initial begin
    repeat (20) @(posedge clock);
    rst_n <= 1'b1;
    wait_idle();
    rd(8'h20, 8'h00, "ptr low reset");
    rd(8'h21, 8'hC0, "ptr high reset");
    rd(8'h22, 8'h00, "bank reset");
    rd(8'h24, 8'h00, "obf reset");
    rd(8'h2A, 8'h0F, "volume reset");
    rd(8'h2B, 8'h88, "mixer reset");
    nib(8'h00 ^ 8'hA5);
    slow <= 1'b1;
    wr(8'h20, 8'h37);
    wait_idle();
    for (int i = 8'h25; i <= 8'h28; i++) wr(8'(i), 8'h33);
    nib(8'h37 ^ 8'hA5);
    rd(8'h20, 8'h38, "ptr low step");
    slow <= 1'b0;
    wr(8'h22, 8'hFF);
    rd(8'h22, 8'h07, "bank width");
    wr(8'h29, 8'h03);
    // Level outputs follow the register one clock later
    repeat (2) @(posedge clock);
    chk("audio ctl", 32'h0000_0003, {30'h0, interp_enable, audio_enable});
    for (int k = 0; k < 8; k++) begin
      wr(8'h2B, {1'b1, k[1:0], k[2], 4'h0});
      n = pops;
      wr(8'h23, 8'h9B);
      wait_pops(n + 8'h01);
      t = mix(voice_channel_zero, voice_channel_one, 8'h9B, k[2], k[1:0]);
      chk("total", {22'h0, t}, {22'h0, last.total});
      chk("vol pwm", 32'h0000_001F, {27'h0, last.volume, last.pwm_sel});
      rd(8'h2B, {1'b1, k[1:0], k[2], t[9:6]}, "mixer msb");
    end
    stall <= 1'b1;
    n = pops;
    repeat (4) wr(8'h23, 8'h10);
    apb(1'b0, 8'h2D, 8'h00, d, e);
    chk("fifo full", 32'h0000_0001, {31'h0, d[6]});
    stall <= 1'b0;
    wait_pops(n + 8'h04);
    chk("drained", 32'h0000_0000, {31'h0, sample_valid});
    rd(8'h2D, 8'h00, "fifo not full");
    rd(8'h24, 8'h10, "obf from ch2 write");
    wr(8'h24, 8'h5A);
    rd(8'h24, 8'h5A, "obf rw");
    wr(8'h2A, 8'h03);
    rd(8'h2A, 8'h03, "volume rw");
    apb(1'b0, 8'h30, 8'h00, d, e);
    chk("unmapped err", 32'h0000_0001, {31'h0, e});
    chk("unmapped data", 32'h0000_0000, d);
    wr(8'h2D, 8'h01);
    wr(8'h22, 8'h06);
    step(8'hFF, 8'hC0, 3'h7);
    step(8'hC5, 8'hC6, 3'h7);
    wr(8'h2D, 8'h00);
    step(8'hC5, 8'hC5, 3'h7);
    results();
  end

  // Watchdog: the full sequence needs only a few hundred cycles
  initial begin
    repeat (20000) @(posedge clock);
    failures++;
    results();
  end
endmodule : vrm_mixer_tb_top
`default_nettype wire
